// ==== include/ext_bus_pin_mux_pkg.sv ====
// Package holding the register map, field layout and reset values of the pin mux.
package ext_bus_pin_mux_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFF_EXT_BUS_CONTROL = 8'h00;
  localparam logic [7:0] OFF_PORTB_PERIPH_ENABLE = 8'h04;
  localparam logic [7:0] OFF_CLOCK_OUT_SELECT = 8'h08;
  localparam logic [7:0] OFF_PORTF_DIRECTION = 8'h0c;
  localparam logic [7:0] OFF_PORTF_PULLUP = 8'h10;
  localparam logic [7:0] OFF_PORTF_DATA_OUT = 8'h14;
  localparam logic [7:0] OFF_PORTF_DATA_IN = 8'h18;
  localparam logic [7:0] OFF_PORTB_DATA_OUT = 8'h1c;
  localparam logic [7:0] OFF_PORTB_DIRECTION = 8'h20;
  localparam logic [7:0] OFF_PORTB_DATA_IN = 8'h24;
  localparam logic [7:0] OFF_PIN_STATUS = 8'h28;
  localparam logic [7:0] OFF_PORTF_PERIPH_ENABLE = 8'h2c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BUS_DRIVE_HOLD_BIT = 0;
  localparam int PORTF_LOW_BIT = 9;
  localparam int PORTB_LOW_BIT = 4;
  localparam int STATUS_BUS_ACTIVE_BIT = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic RST_BUS_DRIVE_HOLD = 1'b0;
  localparam logic [3:0] RST_PORTB_PERIPH_ENABLE = 4'h0;
  localparam logic [3:0] RST_CLOCK_OUT_SELECT = 4'h0;
  localparam logic [6:0] RST_PORTF_PERIPH_ENABLE = 7'h7f;
  localparam logic [6:0] RST_PORTF_DIRECTION = 7'h00;
  localparam logic [6:0] RST_PORTF_PULLUP = 7'h7f;
  localparam logic [6:0] RST_PORTF_DATA_OUT = 7'h00;
  localparam logic [3:0] RST_PORTB_DATA_OUT = 4'h0;
  localparam logic [3:0] RST_PORTB_DIRECTION = 4'h0;

endpackage

// ==== logic/ext_bus_pin_mux.sv ====
// Pin multiplexer for address lines 20-23 and data lines 0-6.
// Function
// - Unless bus_drive_hold is set, address 20-23 and bus controls float while the bus is idle.
// - Unless bus_drive_hold is set, data 0-6 float while the bus is idle.
// - Port B pins 4-7 can carry prescaler, system, doubled system and oscillator clocks.
// - Port B pins 4-7 come out of reset as general-purpose I/O.
// - A set bit in portb_periph_enable_reg hands that port B pin to the peripheral path.
// - For a peripheral pin, clock_out_select_reg picks clock monitor over address.
// - The shared data / port F 9-15 pins come out of reset as data bus pins.
// - In GPIO use, each shared data pin has its own direction bit.
// - Clearing a port F bit in portf_pullup_reg disables that pin's pull-up.
//
// The register addresses and the APB register port are this design's own decisions.
module ext_bus_pin_mux
  import ext_bus_pin_mux_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic bus_active_i,
  input wire logic [3:0] emi_addr_i,
  input wire logic [2:0] emi_ctrl_i,
  input wire logic [6:0] emi_data_out_i,
  input wire logic emi_data_write_i,
  output logic [6:0] emi_data_in_o,
  input wire logic prescaler_clock_i,
  input wire logic system_clock_monitor_i,
  input wire logic system_clock_double_monitor_i,
  input wire logic oscillator_clock_i,
  output logic [3:0] portb_pin_o,
  output logic [3:0] portb_pin_oe_n_o,
  input wire logic [3:0] portb_pin_i,
  output logic [2:0] emi_ctrl_pin_o,
  output logic [2:0] emi_ctrl_pin_oe_n_o,
  output logic [6:0] data_pin_o,
  output logic [6:0] data_pin_oe_n_o,
  input wire logic [6:0] data_pin_i,
  output logic [6:0] data_pin_pullup_o
);
  import ext_bus_pin_mux_pkg::*;

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic bus_drive_hold, next_bus_drive_hold;
  logic [3:0] portb_periph_enable_reg, next_portb_periph_enable_reg;
  logic [3:0] clock_out_select_reg, next_clock_out_select_reg;
  logic [6:0] portf_periph_enable_reg, next_portf_periph_enable_reg;
  logic [6:0] portf_dir_reg, next_portf_dir_reg;
  logic [6:0] portf_pullup_reg, next_portf_pullup_reg;
  logic [6:0] portf_out_reg, next_portf_out_reg;
  logic [3:0] portb_out_reg, next_portb_out_reg;
  logic [3:0] portb_dir_reg, next_portb_dir_reg;
  logic [31:0] prdata, next_prdata;
  logic [6:0] data_meta, data_sync;
  logic [3:0] portb_meta, portb_sync;
  logic wr_en, rd_en, hit;

  // ****************************************************************
  // APB slave: zero wait states, unmapped addresses give pslverr
  // ****************************************************************
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;
  assign prdata_o = prdata;

  always_comb
  begin
    hit = 1'b1;
    unique case (paddr_i)
      OFF_EXT_BUS_CONTROL, OFF_PORTB_PERIPH_ENABLE, OFF_CLOCK_OUT_SELECT,
      OFF_PORTF_DIRECTION, OFF_PORTF_PULLUP, OFF_PORTF_DATA_OUT,
      OFF_PORTF_DATA_IN, OFF_PORTB_DATA_OUT, OFF_PORTB_DIRECTION,
      OFF_PORTB_DATA_IN, OFF_PIN_STATUS, OFF_PORTF_PERIPH_ENABLE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr_o = psel_i && penable_i && !hit;

  always_comb
  begin
    next_bus_drive_hold = bus_drive_hold;
    next_portb_periph_enable_reg = portb_periph_enable_reg;
    next_clock_out_select_reg = clock_out_select_reg;
    next_portf_periph_enable_reg = portf_periph_enable_reg;
    next_portf_dir_reg = portf_dir_reg;
    next_portf_pullup_reg = portf_pullup_reg;
    next_portf_out_reg = portf_out_reg;
    next_portb_out_reg = portb_out_reg;
    next_portb_dir_reg = portb_dir_reg;
    next_prdata = prdata;
    if (wr_en)
    begin
      unique case (paddr_i)
        OFF_EXT_BUS_CONTROL:
          next_bus_drive_hold = pwdata_i[BUS_DRIVE_HOLD_BIT];
        OFF_PORTB_PERIPH_ENABLE:
          next_portb_periph_enable_reg = pwdata_i[PORTB_LOW_BIT +: 4];
        OFF_CLOCK_OUT_SELECT:
          next_clock_out_select_reg = pwdata_i[PORTB_LOW_BIT +: 4];
        OFF_PORTF_PERIPH_ENABLE:
          next_portf_periph_enable_reg = pwdata_i[PORTF_LOW_BIT +: 7];
        OFF_PORTF_DIRECTION:
          next_portf_dir_reg = pwdata_i[PORTF_LOW_BIT +: 7];
        OFF_PORTF_PULLUP:
          next_portf_pullup_reg = pwdata_i[PORTF_LOW_BIT +: 7];
        OFF_PORTF_DATA_OUT:
          next_portf_out_reg = pwdata_i[PORTF_LOW_BIT +: 7];
        OFF_PORTB_DATA_OUT:
          next_portb_out_reg = pwdata_i[PORTB_LOW_BIT +: 4];
        OFF_PORTB_DIRECTION:
          next_portb_dir_reg = pwdata_i[PORTB_LOW_BIT +: 4];
        default: ;
      endcase
    end
    if (rd_en)
    begin
      next_prdata = 32'h0000_0000;
      unique case (paddr_i)
        OFF_EXT_BUS_CONTROL:
          next_prdata[BUS_DRIVE_HOLD_BIT] = bus_drive_hold;
        OFF_PORTB_PERIPH_ENABLE:
          next_prdata[PORTB_LOW_BIT +: 4] = portb_periph_enable_reg;
        OFF_CLOCK_OUT_SELECT:
          next_prdata[PORTB_LOW_BIT +: 4] = clock_out_select_reg;
        OFF_PORTF_PERIPH_ENABLE:
          next_prdata[PORTF_LOW_BIT +: 7] = portf_periph_enable_reg;
        OFF_PORTF_DIRECTION:
          next_prdata[PORTF_LOW_BIT +: 7] = portf_dir_reg;
        OFF_PORTF_PULLUP:
          next_prdata[PORTF_LOW_BIT +: 7] = portf_pullup_reg;
        OFF_PORTF_DATA_OUT:
          next_prdata[PORTF_LOW_BIT +: 7] = portf_out_reg;
        OFF_PORTF_DATA_IN:
          next_prdata[PORTF_LOW_BIT +: 7] = data_sync;
        OFF_PORTB_DATA_OUT:
          next_prdata[PORTB_LOW_BIT +: 4] = portb_out_reg;
        OFF_PORTB_DIRECTION:
          next_prdata[PORTB_LOW_BIT +: 4] = portb_dir_reg;
        OFF_PORTB_DATA_IN:
          next_prdata[PORTB_LOW_BIT +: 4] = portb_sync;
        OFF_PIN_STATUS:
          next_prdata[STATUS_BUS_ACTIVE_BIT] = bus_active_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_drive_hold <= RST_BUS_DRIVE_HOLD;
      portb_periph_enable_reg <= RST_PORTB_PERIPH_ENABLE;
      clock_out_select_reg <= RST_CLOCK_OUT_SELECT;
      portf_periph_enable_reg <= RST_PORTF_PERIPH_ENABLE;
      portf_dir_reg <= RST_PORTF_DIRECTION;
      portf_pullup_reg <= RST_PORTF_PULLUP;
      portf_out_reg <= RST_PORTF_DATA_OUT;
      portb_out_reg <= RST_PORTB_DATA_OUT;
      portb_dir_reg <= RST_PORTB_DIRECTION;
      prdata <= 32'h0000_0000;
      data_meta <= 7'h00;
      data_sync <= 7'h00;
      portb_meta <= 4'h0;
      portb_sync <= 4'h0;
    end
    else
    begin
      bus_drive_hold <= next_bus_drive_hold;
      portb_periph_enable_reg <= next_portb_periph_enable_reg;
      clock_out_select_reg <= next_clock_out_select_reg;
      portf_periph_enable_reg <= next_portf_periph_enable_reg;
      portf_dir_reg <= next_portf_dir_reg;
      portf_pullup_reg <= next_portf_pullup_reg;
      portf_out_reg <= next_portf_out_reg;
      portb_out_reg <= next_portb_out_reg;
      portb_dir_reg <= next_portb_dir_reg;
      prdata <= next_prdata;
      data_meta <= data_pin_i;
      data_sync <= data_meta;
      portb_meta <= portb_pin_i;
      portb_sync <= portb_meta;
    end
  end

  // ****************************************************************
  // Pin muxing
  // ****************************************************************
  logic drive_bus;
  logic [3:0] clock_mon;
  assign drive_bus = bus_active_i || bus_drive_hold;
  assign clock_mon = {oscillator_clock_i, system_clock_double_monitor_i,
                      system_clock_monitor_i, prescaler_clock_i};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (!portb_periph_enable_reg[i])
      begin
        portb_pin_o[i] = portb_out_reg[i];
        portb_pin_oe_n_o[i] = !portb_dir_reg[i];
      end
      else if (clock_out_select_reg[i])
      begin
        portb_pin_o[i] = clock_mon[i];
        portb_pin_oe_n_o[i] = 1'b0;
      end
      else
      begin
        portb_pin_o[i] = emi_addr_i[i];
        portb_pin_oe_n_o[i] = !drive_bus;
      end
    end
  end

  assign emi_ctrl_pin_o = emi_ctrl_i;
  assign emi_ctrl_pin_oe_n_o = {3{!drive_bus}};

  always_comb
  begin
    for (int i = 0; i < 7; i++)
    begin
      if (portf_periph_enable_reg[i])
      begin
        data_pin_o[i] = emi_data_out_i[i];
        data_pin_oe_n_o[i] = !(rst_n_i && drive_bus && emi_data_write_i);
      end
      else
      begin
        data_pin_o[i] = portf_out_reg[i];
        data_pin_oe_n_o[i] = !portf_dir_reg[i];
      end
    end
  end

  // Reset forces data pin drivers off and pull-ups on, whatever the registers hold.
  assign data_pin_pullup_o = rst_n_i ? portf_pullup_reg : RST_PORTF_PULLUP;
  assign emi_data_in_o = data_sync;

endmodule

// ==== verif/ext_bus_pin_mux_sva.sv ====
// Checker of the pin mux port behaviour.
module ext_bus_pin_mux_sva
  import ext_bus_pin_mux_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic bus_active_i,
  input wire logic [2:0] emi_ctrl_pin_oe_n_o,
  input wire logic [6:0] data_pin_oe_n_o,
  input wire logic [6:0] data_pin_pullup_o
);
  // ****************************************************************
  // Shadow of the drive hold bit and the port F function bits.
  // ****************************************************************
  logic hold;
  logic [6:0] pf_per;
  logic wr;
  assign wr = psel_i && penable_i && pwrite_i;
  always_ff @(posedge mclk_i or negedge rst_n_i)
    if (!rst_n_i)
      {hold, pf_per} <= 8'h7f;
    else if (wr && paddr_i == OFF_EXT_BUS_CONTROL)
      hold <= pwdata_i[BUS_DRIVE_HOLD_BIT];
    else if (wr && paddr_i == OFF_PORTF_PERIPH_ENABLE)
      pf_per <= pwdata_i[PORTF_LOW_BIT +: 7];
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  ready_high_a: assert property (pready_o) else $error("pready low");
  bad_addr_a: assert property (psel_i && penable_i && paddr_i > 8'h2c
    |-> pslverr_o) else $error("no error on unmapped address");
  good_addr_a: assert property (psel_i && penable_i && paddr_i <= 8'h2c
    && paddr_i[1:0] == 2'h0 |-> !pslverr_o) else $error("false error");
  ctrl_drive_a: assert property
    (bus_active_i |-> emi_ctrl_pin_oe_n_o == 3'h0) else $error("ctrl float");
  ctrl_float_a: assert property
    (!bus_active_i && !hold |-> emi_ctrl_pin_oe_n_o == 3'h7) else $error("c");
  data_float_a: assert property
    (!bus_active_i && !hold && pf_per == 7'h7f |-> data_pin_oe_n_o == 7'h7f)
    else $error("data pins driven while idle");
  rst_pull_a: assert property (disable iff (1'b0)
    !rst_n_i |-> data_pin_pullup_o == 7'h7f) else $error("pull-up off");
  rst_quiet_a: assert property (disable iff (1'b0)
    !rst_n_i |-> data_pin_oe_n_o == 7'h7f) else $error("data pins driven in reset");
endmodule
bind ext_bus_pin_mux ext_bus_pin_mux_sva ext_bus_pin_mux_sva_i (.*);

// ==== verif/ext_mem_model.sv ====
// Model of the external memory sharing the data pins.
module ext_mem_model
(
  input wire logic mclk_i,
  input wire logic read_i,
  input wire logic [6:0] pin_o_i,
  input wire logic [6:0] pin_oe_n_i,
  input wire logic [6:0] pullup_i,
  output logic [6:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // An undriven pin shows 7'h35 while read_i is high, else pulls up or shows the inverse of its last level.
  // ****************************************************************
  logic [6:0] prev;
  always_ff @(posedge mclk_i)
    prev <= pin_level_o;
  assign pin_level_o = (~pin_oe_n_i & pin_o_i)
    | (pin_oe_n_i & (read_i ? 7'h35 : pullup_i | ~prev));
endmodule

// ==== verif/ext_bus_pin_mux_tb.sv ====
// Self-checking bench of the pin mux.
module ext_bus_pin_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_bus_pin_mux_pkg::*;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) \
    begin fail_count++; \
    $display("wrong value at %0t: %h, expected %h", $time, a, b); end end
  // ****************************************************************
  // Signals, design, memory model and clock.
  // ****************************************************************
  localparam logic [7:0] PF_PER = OFF_PORTF_PERIPH_ENABLE;
  logic mclk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic bus_active_i = 0, emi_data_write_i = 0, mem_rd = 0, err;
  logic pready_o, pslverr_o;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic [3:0] emi_addr_i = 4'h9, portb_pin_i = 4'h6, mon = 4'ha;
  logic [3:0] portb_pin_o, portb_pin_oe_n_o;
  logic [2:0] emi_ctrl_i = 3'h5, emi_ctrl_pin_o, emi_ctrl_pin_oe_n_o;
  logic [6:0] emi_data_out_i = 7'h2a, emi_data_in_o, data_pin_i, data_pin_o;
  logic [6:0] data_pin_oe_n_o, data_pin_pullup_o;
  int fail_count = 0, n_compared = 0;
  ext_bus_pin_mux ext_bus_pin_mux_i (.prescaler_clock_i(mon[0]),
    .system_clock_monitor_i(mon[1]), .system_clock_double_monitor_i(mon[2]),
    .oscillator_clock_i(mon[3]), .*);
  ext_mem_model ext_mem_model_i (.mclk_i(mclk_i), .read_i(mem_rd),
    .pin_o_i(data_pin_o), .pin_oe_n_i(data_pin_oe_n_o),
    .pullup_i(data_pin_pullup_o), .pin_level_o(data_pin_i));
  initial
    forever #2 mclk_i = ~mclk_i;
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge mclk_i);
    fail_count++;
    stop_test();
  end
  initial
  begin
    repeat (20) @(posedge mclk_i);
    `CHK({data_pin_pullup_o, data_pin_oe_n_o}, 14'h3fff)
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    `CHK(portb_pin_oe_n_o, 4'hf)
    rdchk(OFF_PORTB_PERIPH_ENABLE, 32'h0);
    rdchk(OFF_PORTF_PULLUP, 32'hfe00);
    rdchk(PF_PER, 32'hfe00);
    `CHK({emi_ctrl_pin_oe_n_o, data_pin_oe_n_o}, 10'h3ff)
    `CHK(emi_data_in_o, 7'h7f)
    $display("reset test done");
    bus_active_i <= 1'b1;
    emi_data_write_i <= 1'b1;
    @(posedge mclk_i);
    `CHK({emi_ctrl_pin_oe_n_o, data_pin_oe_n_o}, 10'h0)
    `CHK({emi_ctrl_pin_o, data_pin_o}, {3'h5, 7'h2a})
    emi_data_write_i <= 1'b0;
    mem_rd <= 1'b1;
    repeat (4) @(posedge mclk_i);
    `CHK(emi_data_in_o, 7'h35)
    rdchk(OFF_PIN_STATUS, 32'h1);
    bus_active_i <= 1'b0;
    mem_rd <= 1'b0;
    apb(1'b1, OFF_EXT_BUS_CONTROL, 32'h1);
    `CHK(emi_ctrl_pin_oe_n_o, 3'h0)
    apb(1'b1, OFF_EXT_BUS_CONTROL, 32'h0);
    $display("bus test done");
    apb(1'b1, OFF_PORTB_PERIPH_ENABLE, 32'hf0);
    `CHK(portb_pin_oe_n_o, 4'hf)
    apb(1'b1, OFF_CLOCK_OUT_SELECT, 32'hf0);
    `CHK({portb_pin_oe_n_o, portb_pin_o}, 8'h0a)
    mon <= 4'h5;
    bus_active_i <= 1'b1;
    @(posedge mclk_i);
    `CHK(portb_pin_o, 4'h5)
    apb(1'b1, OFF_CLOCK_OUT_SELECT, 32'h0);
    `CHK({portb_pin_oe_n_o, portb_pin_o}, 8'h09)
    bus_active_i <= 1'b0;
    apb(1'b1, OFF_PORTB_PERIPH_ENABLE, 32'h0);
    `CHK(portb_pin_oe_n_o, 4'hf)
    apb(1'b1, OFF_PORTB_DIRECTION, 32'hf0);
    apb(1'b1, OFF_PORTB_DATA_OUT, 32'h50);
    `CHK({portb_pin_oe_n_o, portb_pin_o}, 8'h05)
    rdchk(OFF_PORTB_DATA_IN, 32'h60);
    $display("port b test done");
    apb(1'b1, PF_PER, 32'h0);
    apb(1'b1, OFF_PORTF_DIRECTION, 32'h5400);
    apb(1'b1, OFF_PORTF_DATA_OUT, 32'hfe00);
    `CHK({data_pin_oe_n_o, data_pin_o[1]}, 8'hab)
    apb(1'b1, OFF_PORTF_PULLUP, 32'hfc00);
    `CHK(data_pin_pullup_o, 7'h7e)
    mem_rd <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rdchk(OFF_PORTF_DATA_IN, 32'h7e00);
    mem_rd <= 1'b0;
    apb(1'b0, 8'h30, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("port f test done");
    bus_active_i <= 1'b1;
    emi_data_write_i <= 1'b1;
    rst_n_i <= 1'b0;
    @(posedge mclk_i);
    `CHK({data_pin_pullup_o, data_pin_oe_n_o}, 14'h3fff)
    rst_n_i <= 1'b1;
    bus_active_i <= 1'b0;
    emi_data_write_i <= 1'b0;
    @(posedge mclk_i);
    rdchk(PF_PER, 32'hfe00);
    rdchk(OFF_PORTF_PULLUP, 32'hfe00);
    $display("second reset test done");
    stop_test();
  end
endmodule
